// ===== logic/scp_detector.sv
// Purpose: Setpoint detection on scanned channel words with output updates
// Assumes: Scan engine on pclk delivers one word per cycle at most
// Notes:   Flags double as the setpoint status word read by the scanner
`timescale 1ns/10ps
`default_nettype none
module scp_detector
  import scp_pkg::*;
#(
  parameter int SP_N    = SP_MAX,
  parameter int ENTRY_W = CFG_ENTRY_W
)(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Scan engine
  input  wire logic               scan_start,
  input  wire logic               trigger_in,
  input  wire logic               sample_valid,
  input  wire logic [ENTRY_W-1:0] sample_entry,
  input  wire logic [DATA_W-1:0]  sample_data,
  output logic [SP_N-1:0]         channel_match_flag,
  output logic                    acq_running,
  // Output updates
  output logic [PORT_W-1:0]       aux_digital_out_port,
  output logic                    port_update,
  output logic                    dac_update,
  output logic [DATA_W-1:0]       dac_value,
  output logic                    timer_update,
  output logic                    timer_sel,
  output logic [DATA_W-1:0]       timer_value,
  // Interrupt
  output logic                    irq
);
  if (SP_N < 1 || SP_N > SP_MAX || ENTRY_W < 1 || ENTRY_W > CFG_ENTRY_W) begin : g_chk
    $error("scp_detector: unsupported SP_N or ENTRY_W");
  end

  localparam int IDX_W = 4;

  typedef logic [SP_N-1:0][CFG_W-1:0] scp_cfg_arr_type;

  typedef struct packed {
    scp_state_type             st;
    logic                      arm;
    logic                      gate;
    scp_cfg_arr_type           cfg;
    logic [SP_N-1:0][DATA_W-1:0] lim_a;
    logic [SP_N-1:0][DATA_W-1:0] lim_b;
    logic [SP_N-1:0][DATA_W-1:0] val1;
    logic [SP_N-1:0][DATA_W-1:0] val2;
    logic [SP_N-1:0]           flag;
    logic [SP_N-1:0]           done;
    logic [IRQ_W-1:0]          irq_stat;
    logic [IRQ_W-1:0]          irq_mask;
    logic [PORT_W-1:0]         port;
    logic                      port_upd;
    logic                      dac_upd;
    logic [DATA_W-1:0]         dac_val;
    logic                      tmr_upd;
    logic                      tmr_sel;
    logic [DATA_W-1:0]         tmr_val;
  } scp_core_type;

  scp_core_type cur;
  scp_core_type next_cur;

  scp_reg_if rif ();

  scp_apb_slave u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rif     (rif)
  );

  // Lowest-numbered enabled setpoint on the entry; extras never fire
  function automatic logic [IDX_W:0] find_sp(input scp_cfg_arr_type cfgs,
                                             input logic [ENTRY_W-1:0] entry);
    logic [IDX_W:0] res;
    res = '0;
    for (int i = SP_N - 1; i >= 0; i--) begin
      if (cfgs[i][CFG_EN] &&
          cfgs[i][CFG_ENTRY_LSB +: ENTRY_W] == entry) begin
        res = {1'b1, IDX_W'(i)};
      end
    end
    return res;
  endfunction

  // Setpoint window decode: {hit, index, register}
  function automatic logic [IDX_W+3:0] sp_decode(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = a[11:9] == SP_WIN_BASE && 32'(a[8:5]) < SP_N &&
          a[4:2] <= SP_REG_VAL2 && a[1:0] == 2'h0;
    return {hit, a[8:5], a[4:2]};
  endfunction

  logic [IDX_W:0]   sel;
  logic [IDX_W-1:0] sidx;
  logic [CFG_W-1:0] scfg;
  logic             met;
  logic             hold;
  logic             eval;
  logic [IDX_W+3:0] wdec;
  logic [IDX_W+3:0] rdec;
  logic [IDX_W-1:0] widx;
  logic [IDX_W-1:0] ridx;

  assign sel  = find_sp(cur.cfg, sample_entry);
  assign sidx = sel[IDX_W-1:0];
  assign scfg = cur.cfg[sidx];
  assign wdec = sp_decode(rif.addr);
  assign rdec = sp_decode(rif.addr);
  assign widx = wdec[IDX_W+2:3];
  assign ridx = rdec[IDX_W+2:3];

  scp_criterion u_crit (
    .crit   (scfg[CFG_CRIT_LSB +: 3]),
    .lim_a  (cur.lim_a[sidx]),
    .lim_b  (cur.lim_b[sidx]),
    .sample (sample_data),
    .met    (met),
    .hold   (hold)
  );

  // One evaluation per setpoint per scan, on the entry's own word
  assign eval = (cur.st == ST_RUN) && sample_valid && sel[IDX_W] &&
                !cur.done[sidx];

  // Register read mux
  always_comb begin
    rif.rdata = 32'h0;
    rif.err   = 1'b0;
    if (rdec[IDX_W+3]) begin
      unique case (rdec[2:0])
        SP_REG_CFG:  rif.rdata = 32'(cur.cfg[ridx]);
        SP_REG_LIMA: rif.rdata = 32'(cur.lim_a[ridx]);
        SP_REG_LIMB: rif.rdata = 32'(cur.lim_b[ridx]);
        SP_REG_VAL1: rif.rdata = 32'(cur.val1[ridx]);
        SP_REG_VAL2: rif.rdata = 32'(cur.val2[ridx]);
        default:     rif.err   = 1'b1;
      endcase
    end else begin
      unique case (rif.addr)
        OFS_CTRL:     rif.rdata = 32'({cur.gate, cur.arm});
        OFS_STATUS:   rif.rdata = 32'(cur.flag);
        OFS_IRQ_STAT: rif.rdata = 32'(cur.irq_stat);
        OFS_IRQ_MASK: rif.rdata = 32'(cur.irq_mask);
        OFS_PORT:     rif.rdata = 32'(cur.port);
        default:      rif.err   = 1'b1;
      endcase
    end
  end

  always_comb begin
    logic [IRQ_W-1:0]  set;
    logic [IRQ_W-1:0]  clr;
    logic              act;
    logic [DATA_W-1:0] val;
    set = '0;
    clr = '0;
    act = 1'b0;
    val = '0;
    next_cur = cur;
    next_cur.port_upd = 1'b0;
    next_cur.dac_upd  = 1'b0;
    next_cur.tmr_upd  = 1'b0;

    // Register writes
    if (rif.wr) begin
      if (wdec[IDX_W+3]) begin
        unique case (wdec[2:0])
          SP_REG_CFG:  next_cur.cfg[widx]   = rif.wdata[CFG_W-1:0];
          SP_REG_LIMA: next_cur.lim_a[widx] = rif.wdata[DATA_W-1:0];
          SP_REG_LIMB: next_cur.lim_b[widx] = rif.wdata[DATA_W-1:0];
          SP_REG_VAL1: next_cur.val1[widx]  = rif.wdata[DATA_W-1:0];
          SP_REG_VAL2: next_cur.val2[widx]  = rif.wdata[DATA_W-1:0];
          default:     next_cur.val2[widx]  = cur.val2[widx];
        endcase
      end else begin
        unique case (rif.addr)
          OFS_CTRL: begin
            next_cur.arm  = rif.wdata[CTRL_ARM];
            next_cur.gate = rif.wdata[CTRL_GATE];
          end
          OFS_IRQ_STAT: clr = rif.wdata[IRQ_W-1:0];
          OFS_IRQ_MASK: next_cur.irq_mask = rif.wdata[IRQ_W-1:0];
          // Port drives its reset value of zero until set; preload before scanning
          OFS_PORT:     next_cur.port = rif.wdata[PORT_W-1:0];
          default:      next_cur.arm  = cur.arm;
        endcase
      end
    end

    // Acquisition state
    unique case (cur.st)
      ST_IDLE: begin
        if (cur.arm) begin
          next_cur.st   = cur.gate ? ST_WAIT : ST_RUN;
          next_cur.done = '0;
        end
      end
      ST_WAIT: begin
        if (!cur.arm) begin
          next_cur.st = ST_IDLE;
        end else if (trigger_in) begin
          next_cur.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!cur.arm) begin
          next_cur.st = ST_IDLE;
        end
      end
    endcase

    // New scan period reopens every setpoint
    if (scan_start) begin
      next_cur.done = '0;
    end

    // Evaluation; status word placed last means all flags settled
    if (eval) begin
      next_cur.done[sidx] = 1'b1;
      if (scfg[CFG_CRIT_LSB +: 3] == CRIT_HYST) begin
        if (!hold) begin
          next_cur.flag[sidx] = met;
          act = 1'b1;
        end
      end else begin
        next_cur.flag[sidx] = met;
        act = met || scfg[CFG_TF];
      end
      val = met ? cur.val1[sidx] : cur.val2[sidx];
      if (act) begin
        unique case (scfg[CFG_TGT_LSB +: 2])
          TGT_PORT: begin
            // High byte masks which port bits the low byte drives
            next_cur.port = (cur.port & ~val[15:8]) | (val[7:0] & val[15:8]);
            next_cur.port_upd = 1'b1;
          end
          TGT_DAC: begin
            next_cur.dac_val = val;
            next_cur.dac_upd = 1'b1;
          end
          TGT_TIMER: begin
            next_cur.tmr_val = val;
            next_cur.tmr_sel = scfg[CFG_TSEL];
            next_cur.tmr_upd = 1'b1;
          end
          default: next_cur.port_upd = 1'b0;
        endcase
        set[IRQ_UPD] = scfg[CFG_TGT_LSB +: 2] != TGT_NONE;
      end
      set[IRQ_RISE] = next_cur.flag[sidx] && !cur.flag[sidx];
      set[IRQ_FALL] = !next_cur.flag[sidx] && cur.flag[sidx];
    end

    // Set wins over a same-cycle clear
    next_cur.irq_stat = (cur.irq_stat & ~clr) | set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur    <= '0;
      cur.st <= ST_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  assign channel_match_flag   = cur.flag;
  assign acq_running          = cur.st == ST_RUN;
  assign aux_digital_out_port = cur.port;
  assign port_update          = cur.port_upd;
  assign dac_update           = cur.dac_upd;
  assign dac_value            = cur.dac_val;
  assign timer_update         = cur.tmr_upd;
  assign timer_sel            = cur.tmr_sel;
  assign timer_value          = cur.tmr_val;
  assign irq                  = |(cur.irq_stat & cur.irq_mask);
endmodule
`default_nettype wire

// ===== logic/scp_pkg.sv
// Purpose: Shared constants and types for the scan setpoint detector
// Assumes: 32-bit APB register space, 16-bit channel words
// Notes:   Setpoint registers sit in a strided window above the globals
`default_nettype none
package scp_pkg;
  localparam int SP_MAX = 16;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 12;
  localparam int CFG_W  = 13;
  localparam int IRQ_W  = 3;
  localparam int PORT_W = 8;

  // Global register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_PORT     = 12'h010;

  // Setpoint window: addr[11:9] = base, addr[8:5] = index, addr[4:2] = register
  localparam logic [2:0] SP_WIN_BASE = 3'h1;
  localparam logic [2:0] SP_REG_CFG  = 3'h0;
  localparam logic [2:0] SP_REG_LIMA = 3'h1;
  localparam logic [2:0] SP_REG_LIMB = 3'h2;
  localparam logic [2:0] SP_REG_VAL1 = 3'h3;
  localparam logic [2:0] SP_REG_VAL2 = 3'h4;

  // Control bits
  localparam int CTRL_ARM  = 0;
  localparam int CTRL_GATE = 1;

  // Setpoint configuration field positions
  localparam int CFG_ENTRY_LSB = 0;
  localparam int CFG_ENTRY_W   = 5;
  localparam int CFG_CRIT_LSB  = 5;
  localparam int CFG_TF        = 8;
  localparam int CFG_TGT_LSB   = 9;
  localparam int CFG_TSEL      = 11;
  localparam int CFG_EN        = 12;

  // Criteria codes
  localparam logic [2:0] CRIT_EQ   = 3'h0;
  localparam logic [2:0] CRIT_LT   = 3'h1;
  localparam logic [2:0] CRIT_GT   = 3'h2;
  localparam logic [2:0] CRIT_IN   = 3'h3;
  localparam logic [2:0] CRIT_OUT  = 3'h4;
  localparam logic [2:0] CRIT_HYST = 3'h5;

  // Output targets
  localparam logic [1:0] TGT_NONE  = 2'h0;
  localparam logic [1:0] TGT_PORT  = 2'h1;
  localparam logic [1:0] TGT_DAC   = 2'h2;
  localparam logic [1:0] TGT_TIMER = 2'h3;

  // Interrupt status bits
  localparam int IRQ_RISE = 0;
  localparam int IRQ_FALL = 1;
  localparam int IRQ_UPD  = 2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN  = 3'b100
  } scp_state_type;
endpackage
`default_nettype wire

// ===== logic/scp_reg_if.sv
// Purpose: Carrier between the APB front end and the detector core
// Assumes: Single clock, zero-wait APB
// Notes:   rdata and err are combinational from addr
`timescale 1ns/10ps
`default_nettype none
interface scp_reg_if;
  import scp_pkg::*;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       wdata;
  logic [31:0]       rdata;
  logic              err;
  modport bus  (output wr, output addr, output wdata, input rdata, input err);
  modport core (input wr, input addr, input wdata, output rdata, output err);
endinterface
`default_nettype wire

// ===== logic/scp_apb_slave.sv
// Purpose: APB slave front end, zero wait states
// Assumes: Master holds the request through the access phase
// Notes:   Read data captured in setup so it comes from a flop
`timescale 1ns/10ps
`default_nettype none
module scp_apb_slave
  import scp_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Core side
  scp_reg_if.bus           rif
);
  typedef struct packed {
    logic [31:0] rdata;
    logic        err;
  } scp_apb_type;

  scp_apb_type cur;
  scp_apb_type next_cur;

  assign rif.wr    = psel & penable & pwrite;
  assign rif.addr  = paddr;
  assign rif.wdata = pwdata;
  assign pready    = psel & penable;
  assign prdata    = cur.rdata;
  assign pslverr   = psel & penable & cur.err;

  always_comb begin
    next_cur = cur;
    if (psel && !penable) begin
      next_cur.rdata = pwrite ? 32'h0 : rif.rdata;
      next_cur.err   = rif.err;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
endmodule
`default_nettype wire

// ===== logic/scp_criterion.sv
// Purpose: Compare one channel word against a setpoint's two limits
// Assumes: Unsigned 16-bit words, limit A high and limit B low
// Notes:   Purely combinational
`timescale 1ns/10ps
`default_nettype none
module scp_criterion
  import scp_pkg::*;
(
  // Setpoint
  input  wire logic [2:0]        crit,
  input  wire logic [DATA_W-1:0] lim_a,
  input  wire logic [DATA_W-1:0] lim_b,
  // Channel word
  input  wire logic [DATA_W-1:0] sample,
  // Result
  output logic                   met,
  output logic                   hold
);
  logic above;
  logic below;

  assign above = sample > lim_a;
  assign below = sample < lim_b;

  always_comb begin
    hold = 1'b0;
    unique case (crit)
      CRIT_EQ:   met = sample == lim_a;
      CRIT_LT:   met = sample < lim_a;
      CRIT_GT:   met = sample > lim_b;
      CRIT_IN:   met = (sample > lim_b) && (sample < lim_a);
      CRIT_OUT:  met = below || above;
      CRIT_HYST: begin
        // Low side is true; high side wins if limits are crossed
        met  = below && !above;
        hold = !below && !above;
      end
      default:   met = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ===== verification/scp_properties.sv
// Purpose: Port timing checks for the setpoint detector
// Assumes: One clock domain
// Notes:   Every flag or update must trace back to a taken word
`timescale 1ns/10ps
`default_nettype none
module scp_properties
  import scp_pkg::*;
#(
  parameter int SP_N    = SP_MAX,
  parameter int ENTRY_W = CFG_ENTRY_W
)(
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // Bus
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic              pready,
  input wire logic              pslverr,
  // Scan side
  input wire logic              trigger_in,
  input wire logic              sample_valid,
  input wire logic [SP_N-1:0]   channel_match_flag,
  input wire logic              acq_running,
  // Updates
  input wire logic [PORT_W-1:0] aux_digital_out_port,
  input wire logic              port_update,
  input wire logic              dac_update,
  input wire logic [DATA_W-1:0] dac_value,
  input wire logic              timer_update
);
  logic taken;
  logic bus_wr;
  logic go;
  logic upd;
  assign taken  = sample_valid && acq_running;
  assign bus_wr = psel && penable && pwrite;
  assign go     = bus_wr || trigger_in;
  assign upd    = port_update || dac_update || timer_update;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_access: assert property ((psel && penable) == pready)
    else $error("pready not tied to access phase");
  a_err_gated: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  a_flag_cause: assert property (
    $changed(channel_match_flag) |-> $past(taken)) else $error("flag moved without a word");
  a_flag_single: assert property (
    $onehot0(channel_match_flag ^ $past(channel_match_flag))) else $error("two flags moved");
  a_update_cause: assert property (upd |-> $past(taken))
    else $error("update without a word");
  a_idle_quiet: assert property (
    sample_valid && !acq_running |=> !upd && $stable(channel_match_flag))
    else $error("word acted on while stopped");
  a_dac_hold: assert property ($changed(dac_value) |-> dac_update)
    else $error("dac value moved without pulse");
  a_port_hold: assert property (
    $changed(aux_digital_out_port) |-> port_update || $past(bus_wr))
    else $error("port moved without cause");
  a_run_cause: assert property (
    $rose(acq_running) |-> $past(go) || $past(go, 2)) else $error("run without arm");
  c_dac: cover property (dac_update);
  c_port: cover property (port_update);
  c_run: cover property ($rose(acq_running));
  c_timer: cover property (timer_update);
endmodule
bind scp_detector scp_properties #(.SP_N(SP_N), .ENTRY_W(ENTRY_W)) scp_properties_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .trigger_in(trigger_in), .sample_valid(sample_valid),
  .channel_match_flag(channel_match_flag), .acq_running(acq_running),
  .aux_digital_out_port(aux_digital_out_port), .port_update(port_update),
  .dac_update(dac_update), .dac_value(dac_value), .timer_update(timer_update));
`default_nettype wire

// ===== verification/scp_scan_model.sv
// Purpose: Scan engine stand-in feeding channel words
// Assumes: At most one word a cycle, on pclk
// Notes:   Released lines show inverted data, never the last word
`timescale 1ns/10ps
`default_nettype none
module scp_scan_model
  import scp_pkg::*;
(
  // Clock
  input  wire logic              pclk,
  // Scan side
  output logic                   scan_start,
  output logic                   trigger_in,
  output logic                   sample_valid,
  output logic [CFG_ENTRY_W-1:0] sample_entry,
  output logic [DATA_W-1:0]      sample_data
);
  initial begin
    scan_start   = 1'b0;
    trigger_in   = 1'b0;
    sample_valid = 1'b0;
    sample_entry = '0;
    sample_data  = '0;
  end
  task automatic start();
    @(posedge pclk);
    scan_start <= 1'b1;
    @(posedge pclk);
    scan_start <= 1'b0;
  endtask
  task automatic trig();
    @(posedge pclk);
    trigger_in <= 1'b1;
    @(posedge pclk);
    trigger_in <= 1'b0;
  endtask
  task automatic word(input logic [CFG_ENTRY_W-1:0] e, input logic [DATA_W-1:0] x);
    @(posedge pclk);
    sample_valid <= 1'b1;
    sample_entry <= e;
    sample_data  <= x;
  endtask
  // Frame end, status word taken after this
  task automatic idle();
    @(posedge pclk);
    sample_valid <= 1'b0;
    sample_entry <= ~sample_entry;
    sample_data  <= ~sample_data;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Purpose: Self-checking bench for the setpoint detector
// Assumes: Zero-wait APB, words from the scan model
// Notes:   Limit A is 0x64 and limit B 0x32 throughout
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
  $display("FAIL t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
  import scp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, h, u;
  logic        irq, acq_running, port_update, dac_update, timer_update, timer_sel;
  logic        scan_start, trigger_in, sample_valid;
  logic [4:0]  sample_entry;
  logic [7:0]  aux_digital_out_port;
  logic [11:0] paddr;
  logic [15:0] sample_data, dac_value, timer_value, v, channel_match_flag;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] smp [6] = '{16'h0064, 16'h0063, 16'h0032, 16'h0033, 16'h0065, 16'h0031};
  logic [15:0] hx [5]  = '{16'h0078, 16'h004b, 16'h001e, 16'h004b, 16'h0078};
  int          fails = 0;
  int          num_checks = 0;
  int          cyc = 0;
  scp_detector scp_detector_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scan_start(scan_start), .trigger_in(trigger_in),
    .sample_valid(sample_valid), .sample_entry(sample_entry), .sample_data(sample_data),
    .channel_match_flag(channel_match_flag), .acq_running(acq_running),
    .aux_digital_out_port(aux_digital_out_port), .port_update(port_update),
    .dac_update(dac_update), .dac_value(dac_value), .timer_update(timer_update),
    .timer_sel(timer_sel), .timer_value(timer_value), .irq(irq));
  scp_scan_model scp_scan_model_inst (.pclk(pclk), .scan_start(scan_start),
    .trigger_in(trigger_in), .sample_valid(sample_valid), .sample_entry(sample_entry),
    .sample_data(sample_data));
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [11:0] spa(int i, int r);
    return 12'(32'h200 + i * 32 + r * 4);
  endfunction
  // One scan holding a single word, outputs seen mid-cycle
  task automatic ev(input int e, input logic [15:0] x);
    scp_scan_model_inst.start();
    scp_scan_model_inst.word(5'(e), x);
    scp_scan_model_inst.idle();
    @(negedge pclk);
  endtask
  function automatic logic met(logic [2:0] c, logic [15:0] x);
    case (c)
      CRIT_EQ: return x == 16'h0064;
      CRIT_LT: return x < 16'h0064;
      CRIT_GT: return x > 16'h0032;
      CRIT_IN: return x > 16'h0032 && x < 16'h0064;
      default: return x < 16'h0032 || x > 16'h0064;
    endcase
  endfunction
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    forever begin
      @(posedge pclk);
      cyc++;
      if (cyc == 20000) begin
        fails++;
        summarize();
      end
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 12'h020, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    for (int r = 1; r < 5; r++)
      apb(1'b1, spa(0, r), r < 3 ? 32'h64 >> (r - 1) * 1 - (r - 1) * 32'h0 : 32'h1111 * (r - 2));
    apb(1'b1, spa(0, 2), 32'h32);
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (2) @(negedge pclk);
    `CHK(acq_running, 1'b1)
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, spa(0, 0), 32'h1503 | (c << 5));
      for (int k = 0; k < 6; k++) begin
        ev(3, smp[k]);
        `CHK(channel_match_flag[0], met(3'(c), smp[k]))
        `CHK({dac_update, dac_value}, {1'b1, met(3'(c), smp[k]) ? 16'h1111 : 16'h2222})
      end
    end
    apb(1'b1, spa(0, 3), 32'h0fa5);
    apb(1'b1, spa(0, 0), 32'h1223);
    apb(1'b1, OFS_PORT, 32'h3c);
    ev(3, 16'h000a);
    `CHK({port_update, aux_digital_out_port}, 9'h135)
    ev(3, 16'h00c8);
    `CHK({port_update, aux_digital_out_port, channel_match_flag[0]}, 10'h06a)
    apb(1'b1, spa(1, 1), 32'h64);
    apb(1'b1, spa(1, 2), 32'h32);
    apb(1'b1, spa(1, 3), 32'haaaa);
    apb(1'b1, spa(1, 4), 32'h5555);
    apb(1'b1, spa(1, 0), 32'h1ea7);
    // Same entry as setpoint 1; must never fire
    apb(1'b1, spa(2, 0), 32'h1027);
    apb(1'b1, OFS_IRQ_STAT, 32'h7);
    h = 1'b0;
    v = 16'h0;
    for (int k = 0; k < 5; k++) begin
      u = hx[k] > 16'h0064 || hx[k] < 16'h0032;
      if (hx[k] > 16'h0064) h = 1'b0;
      else if (hx[k] < 16'h0032) h = 1'b1;
      if (u) v = h ? 16'haaaa : 16'h5555;
      ev(7, hx[k]);
      `CHK({channel_match_flag[1], timer_update, timer_sel, timer_value}, {h, u, 1'b1, v})
    end
    scp_scan_model_inst.word(5'd7, 16'h001e);
    scp_scan_model_inst.idle();
    @(negedge pclk);
    `CHK(channel_match_flag[1], 1'b0)
    ev(7, 16'h001e);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd, 32'h2)
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    `CHK({rd[2:0], irq}, 4'he)
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    @(negedge pclk);
    `CHK(irq, 1'b1)
    apb(1'b1, OFS_IRQ_STAT, 32'h1);
    @(negedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, OFS_CTRL, 32'h0);
    ev(7, 16'h0078);
    `CHK({acq_running, timer_update, channel_match_flag[1]}, 3'h1)
    apb(1'b1, OFS_CTRL, 32'h3);
    repeat (2) @(negedge pclk);
    `CHK(acq_running, 1'b0)
    scp_scan_model_inst.trig();
    @(negedge pclk);
    `CHK(acq_running, 1'b1)
    apb(1'b1, spa(0, 0), 32'h1743);
    ev(3, 16'h0010);
    `CHK({timer_update, timer_sel, timer_value, channel_match_flag[0]}, 19'h44444)
    summarize();
  end
endmodule
`default_nettype wire
